// [ccp_host_model.sv]
// Behavioural host bus controller that makes I/O cycles on the card command port.
`timescale 1ns/1ps
`default_nettype none
module ccp_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_data,
    input wire logic i_data_oe,
    output var ccp_pkg::ccp_bus_t o_bus
);
    import ccp_pkg::*;
    initial o_bus = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 8'h00};
    ////////////////////////////////////////////////////////////////////////////
    // One access at a time: the bus goes idle between cycles.
    task automatic drive(input logic ext, input logic [1:0] ofs, input logic [7:0] wd, input logic rd);
        @(posedge i_clk);
        o_bus.card_enable_first_n <= ext;
        o_bus.card_enable_second_n <= ~ext;
        o_bus.reg_n <= 1'b0;
        o_bus.addr <= ofs;
        o_bus.wdata <= wd;
        o_bus.iord_n <= ~rd;
        o_bus.iowr_n <= rd;
    endtask : drive
    // Released data lines flip so that a stale value is never mistaken for a driven one.
    task automatic idle();
        o_bus <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ~o_bus.addr, ~o_bus.wdata};
        @(posedge i_clk);
    endtask : idle
    task automatic wr(input logic ext, input logic [1:0] ofs, input logic [7:0] wd);
        drive(ext, ofs, wd, 1'b0);
        @(posedge i_clk);
        idle();
    endtask : wr
    task automatic rd(input logic ext, input logic [1:0] ofs, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        drive(ext, ofs, 8'h00, 1'b1);
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge i_clk);
            if (i_data_oe === 1'b1) begin
                ok = 1'b1;
                d = i_data;
            end
        end
        idle();
    endtask : rd
endmodule : ccp_host_model
`default_nettype wire

// [ccp_pkg.sv]
// Constants, bus carrier and access kinds of the card command port.
package ccp_pkg;
    localparam logic [1:0] OFS_DATA = 2'h0;
    localparam logic [1:0] OFS_CTRL = 2'h1;
    localparam logic [1:0] OFS_SIZE_LO = 2'h2;
    localparam logic [1:0] OFS_SIZE_HI = 2'h3;
    localparam int CMD_PENDING_IRQ_ENABLE = 7;
    localparam int CMD_FREE_IRQ_ENABLE = 6;
    localparam int CMD_RS = 3;
    localparam int CMD_SR = 2;
    localparam int CMD_SW = 1;
    localparam int CMD_HC = 0;
    localparam logic [7:0] ST_RSVD_MASK = 8'h2c;
    localparam logic FREE_RST = 1'b1;
    localparam logic [7:0] DOUT_RST = 8'h00;

    typedef struct packed {
        logic card_enable_first_n;
        logic card_enable_second_n;
        logic reg_n;
        logic iord_n;
        logic iowr_n;
        logic [1:0] addr;
        logic [7:0] wdata;
    } ccp_bus_t;

    typedef enum logic [1:0] {ACC_NONE, ACC_RD, ACC_WR} ccp_acc_t;
endpackage : ccp_pkg

// [ccp_port.sv]
// Card-side command port with data and extended channel register sets.
`timescale 1ns/1ps
`default_nettype none
module ccp_port #(
    parameter int DATA_DEPTH = 256,
    parameter int EXT_DEPTH = 64
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire ccp_pkg::ccp_bus_t i_bus,
    input wire logic i_init_done,
    input wire logic [1:0] i_rx_pop,
    input wire logic [1:0] i_rx_release,
    input wire logic [1:0] i_tx_push,
    input wire logic [1:0][7:0] i_tx_byte,
    input wire logic [1:0] i_tx_commit,
    input wire logic [1:0] i_reinit_req,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_irq_n,
    output logic [1:0] o_rx_done,
    output logic [1:0][7:0] o_rx_byte,
    output logic [1:0][15:0] o_buf_size,
    output logic [1:0] o_tx_ready
);
    import ccp_pkg::*;
    localparam int DEPTH = (DATA_DEPTH > EXT_DEPTH) ? DATA_DEPTH : EXT_DEPTH;
    localparam int AW = $clog2(DEPTH);
    localparam logic [1:0][15:0] MAXSZ = {16'(EXT_DEPTH), 16'(DATA_DEPTH)};

    ////////////////////////////////////////////////////////////////////////////
    logic iord_prev_q, iowr_prev_q, rd_go, wr_go, sel_v, sel_ch, rs_go;
    logic [1:0] pending_irq_enable_q, pending_irq_enable_d, free_irq_enable_q, free_irq_enable_d, sr_q, sr_d, sw_q, sw_d, hc_q, hc_d;
    logic [1:0] data_pending_flag_q, data_pending_flag_d, free_flag_q, free_flag_d;
    logic [1:0] write_length_error_q, write_length_error_d, read_length_error_q, read_length_error_d;
    logic [1:0] reinit_request_flag_q, reinit_request_flag_d, rx_done_q, rx_done_d, mwr, push_ok;
    logic [1:0][15:0] wsize_q, wsize_d, wcnt_q, wcnt_d, rcnt_q, rcnt_d, tsize_q, tsize_d;
    logic [1:0][15:0] tcnt_q, tcnt_d, neg_q, neg_d, rp_q, rp_d;
    logic [1:0][7:0] rxb_q, rxb_d;
    logic [7:0] dout_q, dout_d, rdat;
    logic oe_q, oe_d, irq_n_q, irq_n_d;
    logic [1:0] tx_rdy_q, tx_rdy_d;
    logic [15:0] n, sv;
    ccp_acc_t acc;
    // Separate buffers per direction and per channel keep host and card from deadlocking.
    logic [7:0] rx_mem [2][DEPTH];
    logic [7:0] tx_mem [2][DEPTH];

    // Data channel on the first enable; extended channel on the second only after init.
    assign sel_v = !i_bus.reg_n && (!i_bus.card_enable_first_n ||
                   (!i_bus.card_enable_second_n && i_init_done));
    assign sel_ch = i_bus.card_enable_first_n;
    assign rd_go = !i_bus.iord_n && iord_prev_q;
    assign wr_go = !i_bus.iowr_n && iowr_prev_q;
    // A reset command on either channel resets both.
    assign rs_go = wr_go && sel_v && i_bus.addr == OFS_CTRL && i_bus.wdata[CMD_RS];

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        {pending_irq_enable_d, free_irq_enable_d, sr_d, sw_d, hc_d} = {pending_irq_enable_q, free_irq_enable_q, sr_q, sw_q, hc_q};
        {data_pending_flag_d, free_flag_d} = {data_pending_flag_q, free_flag_q};
        {write_length_error_d, read_length_error_d} = {write_length_error_q, read_length_error_q};
        {reinit_request_flag_d, rx_done_d} = {reinit_request_flag_q, rx_done_q};
        {wsize_d, wcnt_d, rcnt_d, tsize_d, tcnt_d, neg_d, rp_d} =
            {wsize_q, wcnt_q, rcnt_q, tsize_q, tcnt_q, neg_q, rp_q};
        rxb_d = rxb_q;
        dout_d = dout_q;
        rdat = DOUT_RST;
        n = 16'h0000;
        sv = 16'h0000;
        mwr = 2'b00;
        push_ok = 2'b00;
        acc = rd_go ? ACC_RD : (wr_go ? ACC_WR : ACC_NONE);
        for (int c = 0; c < 2; c++) begin
            if (sel_v && sel_ch == 1'(c) && acc != ACC_NONE) begin
                case (i_bus.addr)
                    OFS_DATA: begin
                        if (acc == ACC_WR) begin
                            n = wcnt_q[c] + 16'h0001;
                            mwr[c] = wcnt_q[c] < MAXSZ[c];
                            if (wcnt_q[c] == 16'h0000) begin
                                free_flag_d[c] = 1'b0;
                            end
                            write_length_error_d[c] = n != wsize_q[c];
                            if (n == wsize_q[c]) begin
                                rx_done_d[c] = 1'b1;
                            end
                            wcnt_d[c] = n;
                        end else begin
                            n = rcnt_q[c] + 16'h0001;
                            rdat = tx_mem[c][rcnt_q[c][AW-1:0]];
                            if (rcnt_q[c] == 16'h0000) begin
                                data_pending_flag_d[c] = 1'b0;
                            end
                            read_length_error_d[c] = n != tsize_q[c];
                            rcnt_d[c] = n;
                        end
                    end
                    OFS_CTRL: begin
                        if (acc == ACC_WR) begin
                            pending_irq_enable_d[c] = i_bus.wdata[CMD_PENDING_IRQ_ENABLE];
                            free_irq_enable_d[c] = i_bus.wdata[CMD_FREE_IRQ_ENABLE];
                            sr_d[c] = i_bus.wdata[CMD_SR];
                            sw_d[c] = i_bus.wdata[CMD_SW];
                            hc_d[c] = i_bus.wdata[CMD_HC];
                        end else begin
                            // Reserved positions are forced to zero.
                            rdat = {data_pending_flag_q[c], free_flag_q[c], 1'b0, reinit_request_flag_q[c],
                                    2'b00, write_length_error_q[c], read_length_error_q[c]};
                        end
                    end
                    default: begin
                        // Each half is handled alone, so either byte order works.
                        if (acc == ACC_WR) begin
                            if (sw_q[c]) begin
                                sv = neg_q[c];
                            end else begin
                                sv = wsize_q[c];
                                wcnt_d[c] = 16'h0000;
                            end
                            if (i_bus.addr[0]) begin
                                sv[15:8] = i_bus.wdata;
                            end else begin
                                sv[7:0] = i_bus.wdata;
                            end
                            if (sw_q[c]) begin
                                neg_d[c] = sv;
                            end else begin
                                wsize_d[c] = sv;
                            end
                        end else begin
                            sv = sr_q[c] ? MAXSZ[c] : tsize_q[c];
                            rdat = i_bus.addr[0] ? sv[15:8] : sv[7:0];
                        end
                    end
                endcase
            end
            if (i_rx_pop[c]) begin
                rxb_d[c] = rx_mem[c][rp_q[c][AW-1:0]];
                rp_d[c] = rp_q[c] + 16'h0001;
            end
            // Pending data, errors and partial buffers are dropped by an interface reset.
            if (rs_go) begin
                {data_pending_flag_d[c], write_length_error_d[c], read_length_error_d[c]} = 3'b000;
                {rx_done_d[c], reinit_request_flag_d[c]} = 2'b00;
                {wcnt_d[c], rcnt_d[c], tcnt_d[c], tsize_d[c], rp_d[c]} = '0;
                free_flag_d[c] = FREE_RST;
            end
            // Card events come last so a card flag set beats a host or reset clear in the same cycle.
            push_ok[c] = i_tx_push[c] && !data_pending_flag_q[c] && !read_length_error_q[c] &&
                         tcnt_q[c] < MAXSZ[c] && !rs_go;
            if (push_ok[c]) begin
                tcnt_d[c] = tcnt_q[c] + 16'h0001;
            end
            if (i_tx_commit[c] && tcnt_q[c] != 16'h0000) begin
                data_pending_flag_d[c] = 1'b1;
                tsize_d[c] = tcnt_q[c];
                tcnt_d[c] = 16'h0000;
                rcnt_d[c] = 16'h0000;
            end
            if (i_rx_release[c]) begin
                free_flag_d[c] = 1'b1;
                {rx_done_d[c], wcnt_d[c], rp_d[c]} = '0;
            end
            if (i_reinit_req[c]) begin
                reinit_request_flag_d[c] = 1'b1;
            end
        end
        if (acc == ACC_RD && sel_v) begin
            dout_d = rdat;
        end
        oe_d = !i_bus.iord_n && sel_v;
        irq_n_d = !(|((data_pending_flag_q & pending_irq_enable_q) | (free_flag_q & free_irq_enable_q)));
        // Taken from the next flag values so the registered copy keeps the same timing.
        tx_rdy_d = ~data_pending_flag_d & ~read_length_error_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk) begin
        for (int c = 0; c < 2; c++) begin
            if (mwr[c]) begin
                rx_mem[c][wcnt_q[c][AW-1:0]] <= i_bus.wdata;
            end
            if (push_ok[c]) begin
                tx_mem[c][tcnt_q[c][AW-1:0]] <= i_tx_byte[c];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {iord_prev_q, iowr_prev_q} <= 2'b11;
            {pending_irq_enable_q, free_irq_enable_q, sr_q, sw_q, hc_q} <= '0;
            data_pending_flag_q <= 2'b00;
            free_flag_q <= {2{FREE_RST}};
            {write_length_error_q, read_length_error_q, reinit_request_flag_q, rx_done_q} <= '0;
            {wsize_q, wcnt_q, rcnt_q, tsize_q, tcnt_q, rp_q} <= '0;
            neg_q <= MAXSZ;
            rxb_q <= '0;
            dout_q <= DOUT_RST;
            oe_q <= 1'b0;
            irq_n_q <= 1'b1;
            tx_rdy_q <= 2'h3;
        end else begin
            {iord_prev_q, iowr_prev_q} <= {i_bus.iord_n, i_bus.iowr_n};
            {pending_irq_enable_q, free_irq_enable_q, sr_q, sw_q, hc_q} <= {pending_irq_enable_d, free_irq_enable_d, sr_d, sw_d, hc_d};
            {data_pending_flag_q, free_flag_q} <= {data_pending_flag_d, free_flag_d};
            {write_length_error_q, read_length_error_q} <= {write_length_error_d, read_length_error_d};
            {reinit_request_flag_q, rx_done_q} <= {reinit_request_flag_d, rx_done_d};
            {wsize_q, wcnt_q, rcnt_q, tsize_q, tcnt_q, neg_q, rp_q} <=
                {wsize_d, wcnt_d, rcnt_d, tsize_d, tcnt_d, neg_d, rp_d};
            rxb_q <= rxb_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            irq_n_q <= irq_n_d;
            tx_rdy_q <= tx_rdy_d;
        end
    end

    assign o_data = dout_q;
    assign o_data_oe = oe_q;
    assign o_irq_n = irq_n_q;
    assign o_rx_done = rx_done_q;
    assign o_rx_byte = rxb_q;
    assign o_buf_size = neg_q;
    assign o_tx_ready = tx_rdy_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_first_wr;
        wr_go && sel_v && !sel_ch && i_bus.addr == OFS_DATA && wcnt_q[0] == 16'h0000;
    endsequence
    sequence s_status_rd;
        rd_go && sel_v && i_bus.addr == OFS_CTRL;
    endsequence

    a_wr_first_free: assert property (s_first_wr ##0 !i_rx_release[0] |=> !free_flag_q[0])
        else $error("free not cleared by first write");
    a_wr_len_err: assert property (wr_go && sel_v && !sel_ch && i_bus.addr == OFS_DATA |=>
        write_length_error_q[0] == ($past(wcnt_q[0]) + 16'h0001 != $past(wsize_q[0])))
        else $error("write error flag wrong");
    a_rd_first_flags: assert property (rd_go && sel_v && !sel_ch && i_bus.addr == OFS_DATA &&
        rcnt_q[0] == 16'h0000 && !i_tx_commit[0] |=> !data_pending_flag_q[0] &&
        read_length_error_q[0] == ($past(tsize_q[0]) != 16'h0001))
        else $error("read flags wrong on first read");
    a_rs_both: assert property (rs_go |=> free_flag_q == 2'b11 && write_length_error_q == 2'b00 &&
        read_length_error_q == 2'b00 ##1 o_tx_ready == 2'b11 || data_pending_flag_q != 2'b00)
        else $error("interface reset incomplete");
    a_iir_clear: assert property (rs_go && !i_reinit_req[0] |=> !reinit_request_flag_q[0])
        else $error("reinit flag not cleared");
    a_irq_gate: assert property (|((data_pending_flag_q & pending_irq_enable_q) | (free_flag_q & free_irq_enable_q)) |=> !o_irq_n)
        else $error("interrupt not raised");
    a_status_rsvd: assert property (s_status_rd |=> (o_data & ST_RSVD_MASK) == 8'h00 ##1
        o_data_oe || i_bus.iord_n || !sel_v)
        else $error("reserved status bits nonzero");
    a_ext_gated: assert property (!i_init_done && i_bus.card_enable_first_n |=> !o_data_oe)
        else $error("extended channel answered before init");
    a_size_max: assert property (rd_go && sel_v && !sel_ch && i_bus.addr == OFS_SIZE_LO && sr_q[0] |=>
        o_data == MAXSZ[0][7:0])
        else $error("size read not max size");
endmodule : ccp_port
`default_nettype wire

// [test_ccp_port.sv]
// Self-checking testbench of the card command port.
`timescale 1ns/1ps
`default_nettype none
module test_ccp_port;
    import ccp_pkg::*;
    localparam int PUSH = 0, COMMIT = 1, POP = 2, REINIT = 3, RELEASE = 4;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_init_done = 1'b0;
    logic [1:0] i_rx_pop = '0, i_rx_release = '0, i_tx_push = '0, i_tx_commit = '0, i_reinit_req = '0;
    logic [1:0][7:0] i_tx_byte = '0;
    ccp_bus_t bus;
    logic [7:0] o_data, rdv;
    logic o_data_oe, o_irq_n, ok;
    logic [1:0] o_rx_done, o_tx_ready;
    logic [1:0][7:0] o_rx_byte;
    logic [1:0][15:0] o_buf_size;
    int num_errors = 0, check_count = 0, cycles = 0;
    always #12.5 i_clk = ~i_clk;
    ccp_port #(.DATA_DEPTH(256), .EXT_DEPTH(64)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus(bus),
        .i_init_done(i_init_done), .i_rx_pop(i_rx_pop), .i_rx_release(i_rx_release), .i_tx_push(i_tx_push),
        .i_tx_byte(i_tx_byte), .i_tx_commit(i_tx_commit), .i_reinit_req(i_reinit_req), .o_data(o_data),
        .o_data_oe(o_data_oe), .o_irq_n(o_irq_n), .o_rx_done(o_rx_done), .o_rx_byte(o_rx_byte),
        .o_buf_size(o_buf_size), .o_tx_ready(o_tx_ready));
    ccp_host_model host (.i_clk(i_clk), .i_data(o_data), .i_data_oe(o_data_oe), .o_bus(bus));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // A refused read shows up as a missing enable, folded into bit 8 of the compare.
    task automatic rd_chk(input logic ext, input logic [1:0] ofs, input logic [7:0] exp, input string name);
        host.rd(ext, ofs, rdv, ok);
        check(name, {7'h0, ok, rdv}, {8'h01, exp});
    endtask : rd_chk
    task automatic card(input int kind, input int ch, input logic [7:0] b);
        @(posedge i_clk);
        case (kind)
            PUSH: begin
                i_tx_push[ch] <= 1'b1;
                i_tx_byte[ch] <= b;
            end
            COMMIT: i_tx_commit[ch] <= 1'b1;
            POP: i_rx_pop[ch] <= 1'b1;
            RELEASE: i_rx_release[ch] <= 1'b1;
            default: i_reinit_req[ch] <= 1'b1;
        endcase
        @(posedge i_clk);
        {i_tx_push, i_tx_commit, i_rx_pop, i_reinit_req, i_rx_release} <= '0;
        @(posedge i_clk);
    endtask : card
    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge i_clk);
        check("irq_n", {15'h0, o_irq_n}, {15'h0, exp});
    endtask : irq_chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd_chk(1'b0, OFS_CTRL, 8'h40, "status after reset");
        host.rd(1'b1, OFS_CTRL, rdv, ok);
        check("ext before init", {15'h0, ok}, 16'h0000);
        irq_chk(1'b1);
        $display("test reset done");
        i_init_done <= 1'b1;
        host.wr(1'b0, OFS_CTRL, 8'h01);
        rd_chk(1'b0, OFS_CTRL, 8'h40, "free and no pending");
        host.wr(1'b0, OFS_SIZE_HI, 8'h00);
        host.wr(1'b0, OFS_SIZE_LO, 8'h02);
        host.wr(1'b0, OFS_DATA, 8'ha5);
        rd_chk(1'b0, OFS_CTRL, 8'h02, "first byte");
        host.wr(1'b0, OFS_DATA, 8'h5a);
        rd_chk(1'b0, OFS_CTRL, 8'h00, "last byte");
        check("rx done", {15'h0, o_rx_done[0]}, 16'h0001);
        host.wr(1'b0, OFS_DATA, 8'h3c);
        rd_chk(1'b0, OFS_CTRL, 8'h02, "extra byte");
        host.wr(1'b0, OFS_CTRL, 8'h00);
        card(POP, 0, 8'h00);
        check("popped byte", {8'h0, o_rx_byte[0]}, 16'h00a5);
        host.wr(1'b1, OFS_CTRL, 8'h08);
        rd_chk(1'b0, OFS_CTRL, 8'h40, "reset from ext");
        check("rx done cleared", {15'h0, o_rx_done[0]}, 16'h0000);
        $display("test host to card done");
        card(PUSH, 1, 8'h11);
        card(PUSH, 1, 8'h22);
        card(COMMIT, 1, 8'h00);
        rd_chk(1'b1, OFS_CTRL, 8'hc0, "ext pending");
        rd_chk(1'b1, OFS_SIZE_HI, 8'h00, "ext size hi");
        rd_chk(1'b1, OFS_SIZE_LO, 8'h02, "ext size lo");
        rd_chk(1'b1, OFS_DATA, 8'h11, "ext byte 0");
        rd_chk(1'b1, OFS_CTRL, 8'h41, "first read");
        check("tx ready", {15'h0, o_tx_ready[1]}, 16'h0000);
        rd_chk(1'b1, OFS_DATA, 8'h22, "ext byte 1");
        rd_chk(1'b1, OFS_CTRL, 8'h40, "last read");
        host.rd(1'b1, OFS_DATA, rdv, ok);
        rd_chk(1'b1, OFS_CTRL, 8'h41, "extra read");
        host.wr(1'b0, OFS_CTRL, 8'h08);
        rd_chk(1'b1, OFS_CTRL, 8'h40, "reset from data");
        $display("test card to host done");
        host.wr(1'b0, OFS_CTRL, 8'h04);
        rd_chk(1'b0, OFS_SIZE_LO, 8'h00, "data max lo");
        rd_chk(1'b0, OFS_SIZE_HI, 8'h01, "data max hi");
        host.wr(1'b1, OFS_CTRL, 8'h04);
        rd_chk(1'b1, OFS_SIZE_LO, 8'h40, "ext max lo");
        rd_chk(1'b1, OFS_SIZE_HI, 8'h00, "ext max hi");
        host.wr(1'b0, OFS_CTRL, 8'h02);
        host.wr(1'b0, OFS_SIZE_HI, 8'h00);
        host.wr(1'b0, OFS_SIZE_LO, 8'h20);
        check("buffer size", o_buf_size[0], 16'h0020);
        host.wr(1'b0, OFS_CTRL, 8'h00);
        host.wr(1'b1, OFS_CTRL, 8'h00);
        $display("test size done");
        host.wr(1'b0, OFS_CTRL, 8'h41);
        irq_chk(1'b0);
        host.wr(1'b0, OFS_SIZE_LO, 8'h01);
        host.wr(1'b0, OFS_DATA, 8'h99);
        irq_chk(1'b1);
        check("rx done single", {15'h0, o_rx_done[0]}, 16'h0001);
        card(RELEASE, 0, 8'h00);
        irq_chk(1'b0);
        check("rx done released", {15'h0, o_rx_done[0]}, 16'h0000);
        host.wr(1'b0, OFS_CTRL, 8'h00);
        irq_chk(1'b1);
        card(PUSH, 0, 8'h77);
        card(COMMIT, 0, 8'h00);
        host.wr(1'b0, OFS_CTRL, 8'h80);
        irq_chk(1'b0);
        host.wr(1'b0, OFS_CTRL, 8'h00);
        card(REINIT, 1, 8'h00);
        rd_chk(1'b1, OFS_CTRL, 8'h50, "reinit request");
        host.wr(1'b0, OFS_CTRL, 8'h08);
        rd_chk(1'b1, OFS_CTRL, 8'h40, "reinit cleared");
        rd_chk(1'b0, OFS_CTRL, 8'h40, "pending cleared");
        $display("test interrupt done");
        end_of_test();
    end
endmodule : test_ccp_port
`default_nettype wire
